// ===== debug_break_ctrl.sv
/*
  Debug break and reset control: breakpoint control register,
  master control register, address comparison and single step.
  Assumes the serial link decoder hands over register writes as a
  one-cycle strobe on core_clk_i, and that the processor, the
  comparator byte registers and the reset sequencer sit on the same
  clock, so none of their signals needs a synchroniser.
*/
`timescale 1ns/10ps
`include "debug_break_regs.svh"

module debug_break_ctrl
  import debug_break_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        reg_wr_i,
  input  wire reg_byte_t   reg_addr_i,
  input  wire reg_byte_t   reg_wdata_i,
  input  wire fetch_addr_t comparator0_addr_i,
  input  wire fetch_addr_t comparator1_addr_i,
  input  wire fetch_addr_t comparator2_addr_i,
  input  wire fetch_addr_t fetch_addr_i,
  input  wire logic        first_opcode_fetch_i,
  input  wire logic        instr_done_i,
  input  wire logic        reset_done_i,
  input  wire logic        cpu_low_power_i,
  output logic             break_req_o,
  output logic             break_on_next_instruction_o,
  output logic             device_reset_o,
  output logic             cpu_wake_o
);

  logic comparator2_break_enable_reg;
  logic comparator1_break_enable_reg;
  logic comparator0_break_enable_reg;
  logic comparator1_page_match_reg;
  logic comparator0_page_match_reg;
  logic single_step_reg;
  logic break_on_next_instruction_reg;
  logic debug_reset_request_reg;
  logic cpu_wake_reg;

  logic wr_brk_ctl;
  logic wr_master_ctl;
  logic cmp0_hit;
  logic cmp1_hit;
  logic cmp2_hit;
  logic addr_hit;
  logic step_hit;
  logic break_hit;

  // Reset images of the two control bytes
  localparam reg_byte_t BRK_CTL_RESET    = `BREAKPOINT_CONTROL_RESET;
  localparam reg_byte_t MASTER_CTL_RESET = `DEBUG_MASTER_CONTROL_RESET;

  // Page mode drops the low byte from the compare
  function automatic logic addr_match(
    input fetch_addr_t addr,
    input fetch_addr_t cmp,
    input logic        page
  );
    logic high_eq;
    logic low_eq;
    high_eq = (addr[23:8] == cmp[23:8]);
    low_eq  = (addr[7:0] == cmp[7:0]);
    return high_eq && (page || low_eq);
  endfunction

  assign wr_brk_ctl    = reg_wr_i &&
                         (reg_addr_i == `BREAKPOINT_CONTROL_OFFSET);
  assign wr_master_ctl = reg_wr_i &&
                         (reg_addr_i == `DEBUG_MASTER_CONTROL_OFFSET);

  // comparator 0 full or page match
  assign cmp0_hit = first_opcode_fetch_i && comparator0_break_enable_reg &&
                    addr_match(fetch_addr_i, comparator0_addr_i,
                               comparator0_page_match_reg);
  // comparator 1 full or page match
  assign cmp1_hit = first_opcode_fetch_i && comparator1_break_enable_reg &&
                    addr_match(fetch_addr_i, comparator1_addr_i,
                               comparator1_page_match_reg);
  assign cmp2_hit = first_opcode_fetch_i && comparator2_break_enable_reg &&
                    addr_match(fetch_addr_i, comparator2_addr_i, 1'b0);

  assign step_hit  = single_step_reg && instr_done_i;
  assign addr_hit  = cmp0_hit || cmp1_hit || cmp2_hit;
  assign break_hit = addr_hit || step_hit;

  assign break_req_o                 = break_hit;
  assign break_on_next_instruction_o = break_on_next_instruction_reg;
  assign device_reset_o              = debug_reset_request_reg;
  assign cpu_wake_o                  = cpu_wake_reg;

  // Breakpoint control fields
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      comparator2_break_enable_reg <= 1'b0;
      comparator1_break_enable_reg <= 1'b0;
      comparator0_break_enable_reg <= 1'b0;
      comparator1_page_match_reg   <= 1'b0;
      comparator0_page_match_reg   <= 1'b0;
      single_step_reg              <= 1'b0;
    end
    else if (clk_en_i && wr_brk_ctl)
    begin
      comparator2_break_enable_reg <= reg_wdata_i[`CMP2_ENABLE_BIT];
      comparator1_break_enable_reg <= reg_wdata_i[`CMP1_ENABLE_BIT];
      comparator0_break_enable_reg <= reg_wdata_i[`CMP0_ENABLE_BIT];
      comparator1_page_match_reg   <= reg_wdata_i[`CMP1_PAGE_BIT];
      comparator0_page_match_reg   <= reg_wdata_i[`CMP0_PAGE_BIT];
      single_step_reg              <= reg_wdata_i[`SINGLE_STEP_BIT];
    end
  end

  // Hardware set beats a host write of zero in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      break_on_next_instruction_reg <= BRK_CTL_RESET[`BREAK_ON_NEXT_INSTRUCTION_BIT];
    end
    else if (clk_en_i)
    begin
      if (break_hit)
      begin
        break_on_next_instruction_reg <= 1'b1;
      end
      else if (wr_brk_ctl)
      begin
        break_on_next_instruction_reg <= reg_wdata_i[`BREAK_ON_NEXT_INSTRUCTION_BIT];
      end
    end
  end

  // Reset request; a new request wins over the done strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      debug_reset_request_reg <= MASTER_CTL_RESET[`DEBUG_RESET_BIT];
    end
    else if (clk_en_i)
    begin
      // one starts reset, zero is no action
      if (wr_master_ctl && reg_wdata_i[`DEBUG_RESET_BIT])
      begin
        debug_reset_request_reg <= 1'b1;
      end
      else if (reset_done_i)
      begin
        debug_reset_request_reg <= 1'b0;
      end
    end
  end

  // Wake pulse; reserved bits carry no meaning so any master control write in low power wakes
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cpu_wake_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cpu_wake_reg <= wr_master_ctl && cpu_low_power_i;
    end
  end

  // Checks
  sequence wake_write_s;
    clk_en_i && wr_master_ctl && cpu_low_power_i;
  endsequence

  sequence wake_pulse_s;
    cpu_wake_o ##1 !cpu_wake_o;
  endsequence

  AST_CMP2_BREAK: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (first_opcode_fetch_i && fetch_addr_i == comparator2_addr_i)
      |-> (break_req_o || !comparator2_break_enable_reg))
    else $error("comparator 2 break mismatch");

  AST_CMP1_IGNORED: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!comparator1_break_enable_reg && !cmp0_hit && !cmp2_hit && !step_hit)
      |-> !break_req_o)
    else $error("disabled comparator 1 caused a hit");

  AST_CMP0_FULL: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (comparator0_break_enable_reg && !comparator0_page_match_reg &&
     first_opcode_fetch_i)
      |-> (cmp0_hit == (fetch_addr_i == comparator0_addr_i)))
    else $error("comparator 0 full compare wrong");

  AST_CMP1_PAGE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (comparator1_break_enable_reg && comparator1_page_match_reg &&
     first_opcode_fetch_i)
      |-> (cmp1_hit ==
           (fetch_addr_i[23:8] == comparator1_addr_i[23:8])))
    else $error("comparator 1 page compare wrong");

  AST_CMP0_PAGE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (comparator0_break_enable_reg && comparator0_page_match_reg &&
     first_opcode_fetch_i &&
     fetch_addr_i[23:8] == comparator0_addr_i[23:8])
      |-> break_req_o)
    else $error("comparator 0 page match did not break");

  AST_SINGLE_STEP: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (single_step_reg && instr_done_i && clk_en_i)
      |-> break_req_o ##1 break_on_next_instruction_o)
    else $error("single step did not break");

  AST_RESET_START: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && wr_master_ctl && reg_wdata_i[`DEBUG_RESET_BIT])
      |=> device_reset_o)
    else $error("reset request not taken");

  AST_RESET_ZERO: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && wr_master_ctl && !reg_wdata_i[`DEBUG_RESET_BIT] &&
     !device_reset_o) |=> !device_reset_o)
    else $error("zero write started a reset");

  AST_RESET_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && reset_done_i && device_reset_o &&
     !(wr_master_ctl && reg_wdata_i[`DEBUG_RESET_BIT]))
      |=> !device_reset_o)
    else $error("reset request not cleared");

  AST_WAKE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wake_write_s |=> cpu_wake_o)
    else $error("wake pulse missing");

  AST_NO_WAKE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && !(wr_master_ctl && cpu_low_power_i)) |=> !cpu_wake_o)
    else $error("wake pulse without a write in low power");

  AST_WAKE_PULSE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (wake_write_s ##1 (clk_en_i && !wr_master_ctl)) |-> wake_pulse_s)
    else $error("wake pulse not one cycle");

  AST_ADDR_SETS_NEXT: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i && addr_hit) |=> break_on_next_instruction_o)
    else $error("address break did not set next bit");

  AST_FIRST_FETCH: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!first_opcode_fetch_i && !step_hit) |-> !break_req_o)
    else $error("break outside first opcode fetch");

  AST_OR_OF_CAUSES: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    break_req_o == ((single_step_reg && instr_done_i) ||
      (first_opcode_fetch_i &&
       ((comparator2_break_enable_reg &&
         fetch_addr_i == comparator2_addr_i) ||
        (comparator1_break_enable_reg &&
         fetch_addr_i[23:8] == comparator1_addr_i[23:8] &&
         (comparator1_page_match_reg ||
          fetch_addr_i[7:0] == comparator1_addr_i[7:0])) ||
        (comparator0_break_enable_reg &&
         fetch_addr_i[23:8] == comparator0_addr_i[23:8] &&
         (comparator0_page_match_reg ||
          fetch_addr_i[7:0] == comparator0_addr_i[7:0]))))))
    else $error("break request not the OR of causes");

  AST_HOLD_FROZEN: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!clk_en_i) |=> ($stable(device_reset_o) &&
                     $stable(break_on_next_instruction_o)))
    else $error("state moved with clock enable low");

endmodule

// ===== debug_break_regs.svh
/*
  Offsets, bit positions and reset values of the debug break and
  master control registers. Assumes it is included by bare name.
*/
`ifndef DEBUG_BREAK_REGS_SVH
`define DEBUG_BREAK_REGS_SVH

// Write-space offsets
`define BREAKPOINT_CONTROL_OFFSET   8'h10
`define DEBUG_MASTER_CONTROL_OFFSET 8'h11

// Break control fields
`define BREAK_ON_NEXT_INSTRUCTION_BIT      7
`define CMP2_ENABLE_BIT   5
`define CMP1_ENABLE_BIT   4
`define CMP0_ENABLE_BIT   3
`define CMP1_PAGE_BIT     2
`define CMP0_PAGE_BIT     1
`define SINGLE_STEP_BIT   0

// Master control fields
`define DEBUG_RESET_BIT   7

// Reset values
`define BREAKPOINT_CONTROL_RESET   8'h00
`define DEBUG_MASTER_CONTROL_RESET 8'h00

`endif

// ===== debug_break_pkg.sv
/*
  Types shared by the debug break and reset control block.
  Assumes nothing of its surroundings.
*/
package debug_break_pkg;

  typedef logic [23:0] fetch_addr_t;
  typedef logic [7:0]  reg_byte_t;

endpackage

// ===== debug_host_model.sv
/*
  Debug host model: issues single-byte writes into the register space.
  Assumes the block takes a write on a rising edge with a one-cycle strobe.
*/
`timescale 1ns/10ps
module debug_host_model
  import debug_break_pkg::*;
(
  input  wire logic core_clk_i,
  output logic      reg_wr_o,
  output reg_byte_t reg_addr_o,
  output reg_byte_t reg_wdata_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // Released bus shows inverted data so stale values never match
  task automatic write_reg(input reg_byte_t addr, input reg_byte_t data);
    @(negedge core_clk_i);
    reg_wr_o    = 1'b1;
    reg_addr_o  = addr;
    reg_wdata_o = (addr == 8'h11) ? (data & 8'h80) : data;
    @(negedge core_clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule

// ===== debug_break_ctrl_bench.sv
/*
  Self-checking bench for the debug break and reset control block.
  Assumes the package, register header and host model are compiled first.
*/
`timescale 1ns/10ps
`include "debug_break_regs.svh"
module debug_break_ctrl_bench
  import debug_break_pkg::*;
;
  localparam fetch_addr_t CMP0 = 24'h123456;
  localparam fetch_addr_t CMP1 = 24'hABCDEF;
  localparam fetch_addr_t CMP2 = 24'h0F1E2D;
  logic        core_clk_i  = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        clk_en_i    = 1'b1;
  logic        reg_wr;
  reg_byte_t   reg_addr;
  reg_byte_t   reg_wdata;
  fetch_addr_t fetch_addr  = 24'h000000;
  logic        first_fetch = 1'b0;
  logic        instr_done  = 1'b0;
  logic        reset_done  = 1'b0;
  logic        low_power   = 1'b0;
  logic        brk;
  logic        bon;
  logic        dev_rst;
  logic        wake;
  int          failures     = 0;
  int          total_checks = 0;

  always #25 core_clk_i = ~core_clk_i;

  debug_host_model u_debug_host_model (
    .core_clk_i  (core_clk_i),
    .reg_wr_o    (reg_wr),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata)
  );

  debug_break_ctrl u_debug_break_ctrl (
    .core_clk_i                  (core_clk_i),
    .sys_rst_i                   (sys_rst_i),
    .clk_en_i                    (clk_en_i),
    .reg_wr_i                    (reg_wr),
    .reg_addr_i                  (reg_addr),
    .reg_wdata_i                 (reg_wdata),
    .comparator0_addr_i          (CMP0),
    .comparator1_addr_i          (CMP1),
    .comparator2_addr_i          (CMP2),
    .fetch_addr_i                (fetch_addr),
    .first_opcode_fetch_i        (first_fetch),
    .instr_done_i                (instr_done),
    .reset_done_i                (reset_done),
    .cpu_low_power_i             (low_power),
    .break_req_o                 (brk),
    .break_on_next_instruction_o (bon),
    .device_reset_o              (dev_rst),
    .cpu_wake_o                  (wake)
  );

  task automatic check(input string name, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Config write also clears the break-next bit before each fetch
  task automatic fetch(input reg_byte_t cfg, input fetch_addr_t addr,
                       input logic first, input logic hit);
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, cfg);
    fetch_addr  = addr;
    first_fetch = first;
    #1;
    check("break_req", brk, hit);
    @(negedge core_clk_i);
    first_fetch = 1'b0;
    check("break_next", bon, hit);
  endtask

  task automatic test_cmp0;
    fetch(8'h08, CMP0, 1'b1, 1'b1);
    fetch(8'h08, CMP0 ^ 24'h000001, 1'b1, 1'b0);
    fetch(8'h0A, CMP0 ^ 24'h0000FF, 1'b1, 1'b1);
    fetch(8'h0A, CMP0 ^ 24'h000100, 1'b1, 1'b0);
    fetch(8'h02, CMP0, 1'b1, 1'b0);
    fetch(8'h08, CMP0, 1'b0, 1'b0);
  endtask

  task automatic test_cmp1;
    fetch(8'h10, CMP1, 1'b1, 1'b1);
    fetch(8'h10, CMP1 ^ 24'h0000FF, 1'b1, 1'b0);
    fetch(8'h14, CMP1 ^ 24'h0000FF, 1'b1, 1'b1);
    fetch(8'h14, CMP1 ^ 24'h010000, 1'b1, 1'b0);
    fetch(8'h00, CMP1, 1'b1, 1'b0);
  endtask

  task automatic test_cmp2;
    fetch(8'h20, CMP2, 1'b1, 1'b1);
    fetch(8'h00, CMP2, 1'b1, 1'b0);
    fetch(8'h26, CMP2 ^ 24'h000001, 1'b1, 1'b0);
    fetch(8'h38, CMP1, 1'b1, 1'b1);
  endtask

  task automatic test_step;
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, 8'h01);
    instr_done = 1'b1;
    #1;
    check("step_on", brk, 1'b1);
    @(negedge core_clk_i);
    instr_done = 1'b0;
    check("step_next", bon, 1'b1);
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, 8'h00);
    instr_done = 1'b1;
    #1;
    check("step_off", brk, 1'b0);
    @(negedge core_clk_i);
    instr_done = 1'b0;
  endtask

  task automatic test_reset;
    u_debug_host_model.write_reg(`DEBUG_MASTER_CONTROL_OFFSET, 8'h00);
    check("reset_zero", dev_rst, 1'b0);
    u_debug_host_model.write_reg(`DEBUG_MASTER_CONTROL_OFFSET, 8'h80);
    check("reset_set", dev_rst, 1'b1);
    repeat (3) @(negedge core_clk_i);
    check("reset_hold", dev_rst, 1'b1);
    reset_done = 1'b1;
    @(negedge core_clk_i);
    reset_done = 1'b0;
    check("reset_clear", dev_rst, 1'b0);
  endtask

  // Disabled clock and unmapped offset both leave state alone
  task automatic test_ignored;
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, 8'h00);
    clk_en_i = 1'b0;
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, 8'h08);
    clk_en_i = 1'b1;
    u_debug_host_model.write_reg(8'h12, 8'h80);
    check("unmapped", dev_rst, 1'b0);
    fetch_addr  = CMP0;
    first_fetch = 1'b1;
    #1;
    check("frozen_write", brk, 1'b0);
    @(negedge core_clk_i);
    first_fetch = 1'b0;
  endtask

  // Second reset mid-run must clear fields and a pending reset request
  task automatic test_mid_reset;
    u_debug_host_model.write_reg(`BREAKPOINT_CONTROL_OFFSET, 8'h88);
    u_debug_host_model.write_reg(`DEBUG_MASTER_CONTROL_OFFSET, 8'h80);
    check("pre_reset_req", dev_rst, 1'b1);
    check("pre_reset_next", bon, 1'b1);
    sys_rst_i = 1'b1;
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    check("mid_reset_next", bon, 1'b0);
    check("mid_reset_req", dev_rst, 1'b0);
    fetch_addr  = CMP0;
    first_fetch = 1'b1;
    #1;
    check("mid_reset_cfg", brk, 1'b0);
    @(negedge core_clk_i);
    first_fetch = 1'b0;
    check("mid_reset_hold", bon, 1'b0);
  endtask

  task automatic wake_try(input logic lp, input int exp);
    int n;
    n         = 0;
    low_power = lp;
    u_debug_host_model.write_reg(`DEBUG_MASTER_CONTROL_OFFSET, 8'h00);
    repeat (4)
    begin
      n += (wake === 1'b1);
      @(negedge core_clk_i);
    end
    low_power = 1'b0;
    check("wake_pulses", 8'(n), 8'(exp));
  endtask

  initial
  begin
    #200000;
    failures++;
    summarize();
  end

  initial
  begin
    repeat (6) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    check("bon_reset", bon, 1'b0);
    check("dev_rst_reset", dev_rst, 1'b0);
    test_cmp0();
    test_cmp1();
    test_cmp2();
    test_step();
    test_reset();
    test_ignored();
    wake_try(1'b1, 1);
    wake_try(1'b0, 0);
    test_mid_reset();
    summarize();
  end
endmodule
